/* lcd_cmd_host.sv */
`timescale 1ns/1ps
module lcd_cmd_host #(
   parameter logic [7:0] UPDATE_OPCODE = 8'h00 // value arbitrary
) (
   input wire logic clk,
   input wire logic nrst,
   lcd_cmd_if.host link,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SEND = 3'b010,
      ST_UPD = 3'b100
   } st_t;

   // ****************************************
   // write channel capture
   // ****************************************
   logic aw_have_q, w_have_q;
   logic [3:0] aw_q;
   logic [31:0] w_q;
   logic do_wr, wr_cmd;
   st_t st_q;
   logic busy;

   assign busy = st_q != ST_IDLE;
   assign do_wr = aw_have_q & w_have_q & ~s_axi_bvalid;
   assign wr_cmd = do_wr & (aw_q == lcd_cmd_pkg::OFS_CMD) & (&s_axi_wstrb[1:0]) & ~busy;
   assign s_axi_awready = ~aw_have_q;
   assign s_axi_wready = ~w_have_q;

   // address and data are held separately, so either may come first
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_q <= 4'h0;
         w_q <= 32'h00000000;
      end else begin
         if (s_axi_awvalid && !aw_have_q) begin
            aw_have_q <= 1'b1;
            aw_q <= s_axi_awaddr;
         end else if (do_wr) begin
            aw_have_q <= 1'b0;
         end
         if (s_axi_wvalid && !w_have_q) begin
            w_have_q <= 1'b1;
            w_q <= s_axi_wdata;
         end else if (do_wr) begin
            w_have_q <= 1'b0;
         end
      end
   end

   // write response; a command written while busy is refused with an error
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= lcd_cmd_pkg::RESP_OK;
      end else if (do_wr) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_cmd ? lcd_cmd_pkg::RESP_OK : lcd_cmd_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ****************************************
   // read channel
   // ****************************************
   assign s_axi_arready = ~s_axi_rvalid;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= lcd_cmd_pkg::RESP_OK;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {31'h00000000, busy};
         s_axi_rresp <= (s_axi_araddr == lcd_cmd_pkg::OFS_STATUS) ? lcd_cmd_pkg::RESP_OK
            : lcd_cmd_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ****************************************
   // link sender
   // ****************************************
   logic is_shift;
   assign is_shift = link.cmd_data[7:2] == lcd_cmd_pkg::OP_SHIFT
      && link.register_select_code == lcd_cmd_pkg::RS_INSTR && !link.rw;

   // one byte at a time; a shift is always closed by the update byte
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_q <= ST_IDLE;
         link.cmd_valid <= 1'b0;
         link.cmd_data <= 8'h00;
         link.register_select_code <= lcd_cmd_pkg::RS_INSTR;
         link.rw <= 1'b0;
      end else begin
         case (st_q)
            ST_IDLE: begin
               if (wr_cmd) begin
                  link.cmd_valid <= 1'b1;
                  link.cmd_data <= w_q[7:0];
                  link.register_select_code <= w_q[lcd_cmd_pkg::CMD_RS_LSB +: 2];
                  link.rw <= w_q[lcd_cmd_pkg::CMD_RW_BIT];
                  st_q <= ST_SEND;
               end
            end
            ST_SEND: begin
               if (link.cmd_ready) begin
                  if (is_shift) begin
                     link.cmd_data <= UPDATE_OPCODE;
                     link.register_select_code <= lcd_cmd_pkg::RS_INSTR;
                     link.rw <= 1'b0;
                     st_q <= ST_UPD;
                  end else begin
                     link.cmd_valid <= 1'b0;
                     st_q <= ST_IDLE;
                  end
               end
            end
            ST_UPD: begin
               if (link.cmd_ready) begin
                  link.cmd_valid <= 1'b0;
                  st_q <= ST_IDLE;
               end
            end
            default: begin
               st_q <= ST_IDLE;
               link.cmd_valid <= 1'b0;
            end
         endcase
      end
   end
endmodule // lcd_cmd_host

/* lcd_cmd_if.sv */
`timescale 1ns/1ps
interface lcd_cmd_if;
   logic cmd_valid;
   logic cmd_ready;
   logic [1:0] register_select_code;
   logic rw;
   logic [7:0] cmd_data;
   modport device (input cmd_valid, register_select_code, rw, cmd_data, output cmd_ready);
   modport host (output cmd_valid, register_select_code, rw, cmd_data, input cmd_ready);
endinterface

/* lcd_cmd_pkg.sv */
package lcd_cmd_pkg;
   // ****************************************
   // system timing
   // ****************************************
   localparam int unsigned SYS_HZ = 125000000;
   localparam int unsigned FRAME_CLKS = 800; // internal clocks per frame
   localparam int unsigned BLINK_PERIOD_MS = 1000;
   localparam int unsigned PCT = 100;

   // ****************************************
   // instruction encodings
   // ****************************************
   localparam logic [1:0] RS_INSTR = 2'h2;
   localparam logic [2:0] OP_FRAME_FREQ = 3'h4; // bits 7..5
   localparam logic [4:0] OP_DISP_CTRL = 5'h04; // bits 7..3
   localparam logic [5:0] OP_SHIFT = 6'h04; // bits 7..2
   localparam logic [6:0] OP_SCREEN_CFG = 7'h01; // bits 7..1
   localparam logic [5:0] OP_DISP_CFG = 6'h01; // bits 7..2
   localparam logic [4:0] CODE_DEFAULT = 5'h07;
   localparam logic [4:0] CODE_TOP = 5'h15; // this and above share one rate

   // ****************************************
   // address counter and geometry
   // ****************************************
   localparam logic [6:0] LINE0_LAST = 7'h27;
   localparam logic [6:0] LINE1_FIRST = 7'h40;
   localparam logic [6:0] LINE1_LAST = 7'h67;
   localparam logic [5:0] LINE_LEN = 6'h28;
   localparam logic [7:0] COL_LAST = 8'h63;
   localparam logic [7:0] PAIR_BASE = 8'h64;
   localparam logic [7:0] PAIR_TOP = 8'hc7;
   localparam logic [4:0] ROW_CHAR_LAST = 5'h0f;
   localparam logic [4:0] ROW_ICON_A = 5'h10;
   localparam logic [4:0] ROW_ICON_B = 5'h11;
   localparam logic [4:0] STEPS_FULL = 5'h12; // 1:18
   localparam logic [4:0] STEPS_ONE = 5'h09; // 1:9
   localparam logic [4:0] CHAR_ROWS_FULL = 5'h10;
   localparam logic [4:0] CHAR_ROWS_ONE = 5'h08;
   localparam logic [2:0] CURSOR_DOT_ROW = 3'h7;
   localparam logic [4:0] CURSOR_DOTS = 5'h1f;

   // ****************************************
   // host register map
   // ****************************************
   localparam logic [3:0] OFS_CMD = 4'h0;
   localparam logic [3:0] OFS_STATUS = 4'h4;
   localparam int CMD_RS_LSB = 8;
   localparam int CMD_RW_BIT = 10;
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // internal clock rate for a frame rate code
   function automatic int unsigned clk_hz(input logic [4:0] c);
      case (c)
         5'h00: clk_hz = 36000;
         5'h01: clk_hz = 39724;
         5'h02: clk_hz = 44308;
         5'h03: clk_hz = 48000;
         5'h04: clk_hz = 52364;
         5'h05: clk_hz = 54857;
         5'h06: clk_hz = 60632;
         5'h07: clk_hz = 64000;
         5'h08: clk_hz = 67765;
         5'h09: clk_hz = 72000;
         5'h0a: clk_hz = 76800;
         5'h0b: clk_hz = 82286;
         5'h0c: clk_hz = 88615;
         5'h0d: clk_hz = 96000;
         5'h0e: clk_hz = 104727;
         5'h0f: clk_hz = 115200;
         5'h10: clk_hz = 128000;
         5'h11: clk_hz = 144000;
         5'h12: clk_hz = 164571;
         5'h13: clk_hz = 192000;
         5'h14: clk_hz = 230400;
         default: clk_hz = 288000;
      endcase
   endfunction

   // high share of the internal clock, in percent
   function automatic int unsigned duty_hi(input logic [4:0] c);
      case (c)
         5'h01: duty_hi = 44;
         5'h02, 5'h0c: duty_hi = 38;
         5'h03, 5'h0d, 5'h13: duty_hi = 33;
         5'h04, 5'h0e: duty_hi = 27;
         5'h05: duty_hi = 23;
         5'h06: duty_hi = 15;
         5'h07, 5'h10: duty_hi = 11;
         5'h08: duty_hi = 5;
         5'h0a: duty_hi = 46;
         5'h0b, 5'h12: duty_hi = 42;
         5'h0f, 5'h14: duty_hi = 20;
         default: duty_hi = 50;
      endcase
   endfunction
endpackage

/* lcd_display_control_commands_monitor.sv */
`timescale 1ns/1ps
module lcd_display_control_commands_monitor #(
   parameter logic [7:0] UPDATE_OPCODE = 8'h00
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic cmd_valid,
   input wire logic cmd_ready,
   input wire logic [1:0] register_select_code,
   input wire logic rw,
   input wire logic [7:0] cmd_data
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // ****************************************
   // link handshake steps
   // ****************************************
   sequence taken_s;
      cmd_valid && cmd_ready;
   endsequence
   sequence shift_taken_s;
      taken_s ##0 (cmd_data[7:2] == lcd_cmd_pkg::OP_SHIFT);
   endsequence
   sequence plain_taken_s;
      taken_s ##0 (cmd_data[7:2] != lcd_cmd_pkg::OP_SHIFT);
   endsequence
   // payload may not move while a byte waits
   payload_hold_a: assert property (cmd_valid && !cmd_ready |=> $stable({register_select_code, rw, cmd_data}))
      else $error("link payload moved while waiting");
   valid_hold_a: assert property (cmd_valid && !cmd_ready |=> cmd_valid)
      else $error("link valid dropped before taken");
   instr_code_a: assert property (cmd_valid |-> register_select_code == lcd_cmd_pkg::RS_INSTR)
      else $error("link byte without instruction select");
   write_low_a: assert property (cmd_valid |-> !rw)
      else $error("link byte marked as read");
   // a lone shift never stands: the update byte goes right behind it
   update_follow_a: assert property (shift_taken_s |=> taken_s ##0 cmd_data == UPDATE_OPCODE)
      else $error("shift not followed by update byte");
   spacing_rule_a: assert property (plain_taken_s |=> !cmd_valid)
      else $error("bytes closer than two cycles");
   update_cause_a: assert property (taken_s ##0 cmd_data == UPDATE_OPCODE |-> $past(cmd_data[7:2]) == lcd_cmd_pkg::OP_SHIFT)
      else $error("update byte without a shift before it");
   ready_up_a: assert property (nrst && $past(nrst) |-> cmd_ready)
      else $error("device not ready after reset");
endmodule // lcd_display_control_commands_monitor

/* lcd_display_control_commands_tb.sv */
`timescale 1ns/1ps
module lcd_display_control_commands_tb;
   // ****************************************
   // clock, reset and wiring
   // ****************************************
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [7:0] col_req = 8'h00;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic display_on_q, cursor_on_q, blink_on_q, lcd_clk_q;
   logic [4:0] frame_rate_code_q, cursor_dots_q, drive_row_q;
   logic [6:0] addr_counter_q;
   logic [5:0] scroll_offset_q;
   logic [7:0] col_drive_q, col_pair_q;
   int bad_count = 0;
   int n_tests = 0;
   lcd_cmd_if link ();
   // 8 ns period; bready and rready stay high, which the bus allows
   always #4 clk = ~clk;
   lcd_cmd_host u_lcd_cmd_host (.clk(clk), .nrst(nrst), .link(link), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(1'b1));
   // short frames, so that frame-aligned settings show within the run
   lcd_display_ctrl #(.FRAME_CLKS(18)) u_lcd_display_ctrl (.clk(clk), .nrst(nrst), .link(link),
      .two_line(1'b1), .one_line_mux_select(1'b0), .col_req(col_req),
      .display_on_q(display_on_q), .cursor_on_q(cursor_on_q), .blink_on_q(blink_on_q),
      .frame_rate_code_q(frame_rate_code_q), .lcd_clk_q(lcd_clk_q), .frame_tick_q(),
      .addr_counter_q(addr_counter_q), .scroll_offset_q(scroll_offset_q),
      .drive_row_q(drive_row_q), .cursor_dots_q(cursor_dots_q), .blink_full_q(),
      .col_drive_q(col_drive_q), .col_pair_q(col_pair_q));
   lcd_display_control_commands_monitor u_lcd_display_control_commands_monitor (.clk(clk),
      .nrst(nrst), .cmd_valid(link.cmd_valid), .cmd_ready(link.cmd_ready),
      .register_select_code(link.register_select_code), .rw(link.rw), .cmd_data(link.cmd_data));
   // ****************************************
   // shared tasks
   // ****************************************
   task automatic close_out();
      if (bad_count == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tmo(input int k, input int lim);
      if (k >= lim) begin
         bad_count++;
         close_out();
      end
   endtask
   // valid released per channel on its own handshake edge
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
      int k;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      for (k = 0; k < 200; k++) begin
         @(posedge clk);
         if (awready && awvalid) awvalid <= 1'b0;
         if (wready && wvalid) wvalid <= 1'b0;
         if (bvalid) break;
      end
      tmo(k, 200);
      r = bresp;
   endtask
   task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      int k;
      araddr <= a;
      arvalid <= 1'b1;
      for (k = 0; k < 200; k++) begin
         @(posedge clk);
         if (arready && arvalid) arvalid <= 1'b0;
         if (rvalid) break;
      end
      tmo(k, 200);
      d = rdata;
      r = rresp;
   endtask
   // one instruction byte, then poll until the link is idle again
   task automatic send(input logic [7:0] b);
      logic [31:0] d;
      logic [1:0] r;
      int k;
      axi_wr(lcd_cmd_pkg::OFS_CMD, {22'h0, lcd_cmd_pkg::RS_INSTR, b}, r);
      chk("cmd_resp", r, lcd_cmd_pkg::RESP_OK);
      for (k = 0; k < 50; k++) begin
         axi_rd(lcd_cmd_pkg::OFS_STATUS, d, r);
         if (d[0] === 1'b0) break;
      end
      tmo(k, 50);
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_defaults();
      chk("dcb_off", {display_on_q, cursor_on_q, blink_on_q}, 3'h0);
      chk("rate_code", frame_rate_code_q, lcd_cmd_pkg::CODE_DEFAULT);
      col_req <= 8'h00;
      repeat (2) @(posedge clk);
      chk("pair_lo", col_pair_q, 8'h64);
      chk("drive_lo", col_drive_q, 8'h00);
      col_req <= 8'h63;
      repeat (2) @(posedge clk);
      chk("pair_hi", col_pair_q, 8'hc7);
      chk("drive_hi", col_drive_q, 8'h63);
   endtask
   // refused accesses must not reach the display
   task automatic t_bus();
      logic [31:0] d;
      logic [1:0] r;
      axi_wr(4'h8, 32'h0000_0211, r);
      chk("wr_unmapped", r, lcd_cmd_pkg::RESP_SLVERR);
      axi_rd(4'h8, d, r);
      chk("rd_unmapped", r, lcd_cmd_pkg::RESP_SLVERR);
      chk("ac_kept", addr_counter_q, 7'h00);
   endtask
   task automatic t_shift();
      send(8'h11);
      chk("ac_move", addr_counter_q, 7'h01);
      send(8'h13);
      chk("ac_scroll", addr_counter_q, 7'h01);
      chk("scrolled", scroll_offset_q != 6'h00, 1'b1);
      send(8'h12);
      chk("scroll_back", scroll_offset_q, 6'h00);
      send(8'h10);
      chk("ac_left", addr_counter_q, 7'h00);
   endtask
   // position 40 of line one continues at the start of line two
   task automatic t_wrap();
      repeat (39) send(8'h11);
      chk("ac_end", addr_counter_q, lcd_cmd_pkg::LINE0_LAST);
      send(8'h11);
      chk("ac_line2", addr_counter_q, lcd_cmd_pkg::LINE1_FIRST);
      send(8'h10);
      chk("ac_back", addr_counter_q, lcd_cmd_pkg::LINE0_LAST);
   endtask
   // default code: 64000 Hz is 1953 system cycles, about 11 percent high
   task automatic t_clock();
      int hi, lo, k;
      for (k = 0; k < 5000 && lcd_clk_q !== 1'b0; k++) @(posedge clk);
      for (k = 0; k < 5000 && lcd_clk_q !== 1'b1; k++) @(posedge clk);
      tmo(k, 5000);
      for (hi = 0; hi < 5000 && lcd_clk_q === 1'b1; hi++) @(posedge clk);
      for (lo = 0; lo < 5000 && lcd_clk_q === 1'b0; lo++) @(posedge clk);
      chk("clk_period", (hi + lo > 1950) && (hi + lo < 1957), 1'b1);
      chk("clk_duty", (hi * 100 + (hi + lo) / 2) / (hi + lo), 32'd11);
   endtask
   // all on, mirrored pairing, both orders reversed; seen from the next frame on
   task automatic t_config();
      int k;
      send(8'h27);
      send(8'h03);
      send(8'h07);
      col_req <= 8'h00;
      for (k = 0; k < 40000 && display_on_q !== 1'b1; k++) @(posedge clk);
      tmo(k, 40000);
      repeat (2) @(posedge clk);
      chk("dcb_on", {display_on_q, cursor_on_q, blink_on_q}, 3'h7);
      chk("drive_rev", col_drive_q, 8'h63);
      chk("pair_mirror", col_pair_q, 8'h64);
      for (k = 0; k < 40000 && cursor_dots_q !== 5'h1f; k++) @(posedge clk);
      tmo(k, 40000);
      chk("cursor_row", drive_row_q, 5'h08);
   endtask
   // ****************************************
   // main sequence and watchdog
   // ****************************************
   initial begin
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      t_defaults();
      t_bus();
      t_shift();
      t_wrap();
      t_config();
      t_clock();
      close_out();
   end
   initial begin
      repeat (90000) @(posedge clk);
      tmo(1, 1);
   end
endmodule // lcd_display_control_commands_tb

/* lcd_display_ctrl.sv */
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
module lcd_display_ctrl #(parameter int unsigned FRAME_CLKS = lcd_cmd_pkg::FRAME_CLKS) (
   input wire logic clk,
   input wire logic nrst,
   lcd_cmd_if.device link,
   input wire logic two_line,
   input wire logic one_line_mux_select,
   input wire logic [7:0] col_req,
   output logic display_on_q,
   output logic cursor_on_q,
   output logic blink_on_q,
   output logic [4:0] frame_rate_code_q,
   output logic lcd_clk_q,
   output logic frame_tick_q,
   output logic [6:0] addr_counter_q,
   output logic [5:0] scroll_offset_q,
   output logic [4:0] drive_row_q,
   output logic [4:0] cursor_dots_q,
   output logic blink_full_q,
   output logic [7:0] col_drive_q,
   output logic [7:0] col_pair_q
);
   // ****************************************
   // instruction decode into shadow settings
   // ****************************************
   logic [7:0] op, col_log;
   logic [4:0] sh_code_q;
   logic sh_disp_q, sh_cur_q, sh_blink_q, sh_mirror_q, sh_col_q, sh_row_q;
   logic pend_q, pend_scroll_q, pend_right_q, take, ready_q, col_rev_q, row_rev_q, mirror_q;
   assign op = link.cmd_data;
   assign take = link.cmd_valid & ready_q & (link.register_select_code == lcd_cmd_pkg::RS_INSTR)
      & ~link.rw;
   assign link.cmd_ready = ready_q;
   // ready from the first clock after reset: every instruction is decoded in one cycle
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ready_q <= 1'b0;
      end else begin
         ready_q <= 1'b1;
      end
   end
   // shadow settings, applied to the drive only at a frame boundary
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sh_code_q <= lcd_cmd_pkg::CODE_DEFAULT;
         sh_disp_q <= 1'b0;
         sh_cur_q <= 1'b0;
         sh_blink_q <= 1'b0;
         sh_mirror_q <= 1'b0;
         sh_col_q <= 1'b0;
         sh_row_q <= 1'b0;
      end else if (take) begin
         if (op[7:5] == lcd_cmd_pkg::OP_FRAME_FREQ) begin
            sh_code_q <= op[4:0];
         end else if (op[7:3] == lcd_cmd_pkg::OP_DISP_CTRL) begin
            sh_disp_q <= op[2];
            sh_cur_q <= op[1];
            sh_blink_q <= op[0];
         end else if (op[7:1] == lcd_cmd_pkg::OP_SCREEN_CFG) begin
            sh_mirror_q <= op[0];
         end else if (op[7:2] == lcd_cmd_pkg::OP_DISP_CFG) begin
            sh_col_q <= op[1];
            sh_row_q <= op[0];
         end
      end
   end
   // ****************************************
   // cursor and display shift
   // ****************************************
   // step the counter one place, crossing lines in two-line mode
   function automatic logic [6:0] ac_step(input logic [6:0] a, input logic right,
                                          input logic two);
      logic [6:0] r;
      r = right ? a + 7'h01 : a - 7'h01;
      if (right && a == lcd_cmd_pkg::LINE0_LAST) begin
         r = two ? lcd_cmd_pkg::LINE1_FIRST : 7'h00;
      end else if (right && a == lcd_cmd_pkg::LINE1_LAST) begin
         r = 7'h00;
      end else if (!right && a == 7'h00) begin
         r = two ? lcd_cmd_pkg::LINE1_LAST : lcd_cmd_pkg::LINE0_LAST;
      end else if (!right && a == lcd_cmd_pkg::LINE1_FIRST) begin
         r = lcd_cmd_pkg::LINE0_LAST;
      end
      return r;
   endfunction
   // a shift waits for the next instruction, the update, to take effect
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pend_q <= 1'b0;
         pend_scroll_q <= 1'b0;
         pend_right_q <= 1'b0;
      end else if (take) begin
         pend_q <= op[7:2] == lcd_cmd_pkg::OP_SHIFT;
         if (op[7:2] == lcd_cmd_pkg::OP_SHIFT) begin
            pend_scroll_q <= op[1];
            pend_right_q <= op[0];
         end
      end
   end
   // counter and scroll offset only; no memory port exists here at all
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         addr_counter_q <= 7'h00;
         scroll_offset_q <= 6'h00;
      end else if (take && pend_q) begin
         if (!pend_scroll_q) begin
            addr_counter_q <= ac_step(addr_counter_q, pend_right_q, two_line);
         end else if (pend_right_q) begin
            // one offset for every line, modulo the line length
            scroll_offset_q <= (scroll_offset_q == lcd_cmd_pkg::LINE_LEN - 6'h01) ? 6'h00
               : scroll_offset_q + 6'h01;
         end else begin
            scroll_offset_q <= (scroll_offset_q == 6'h00) ? lcd_cmd_pkg::LINE_LEN - 6'h01
               : scroll_offset_q - 6'h01;
         end
      end
   end
   // ****************************************
   // internal clock and frame timing
   // ****************************************
   logic [15:0] div_cnt_q, per, hi;
   logic tick, frame_end;
   logic [9:0] frm_cnt_q;
   assign per = 16'(lcd_cmd_pkg::SYS_HZ / lcd_cmd_pkg::clk_hz(frame_rate_code_q));
   assign hi = 16'((32'(per) * lcd_cmd_pkg::duty_hi(frame_rate_code_q)) / lcd_cmd_pkg::PCT);
   assign tick = div_cnt_q == per - 16'h0001;
   assign frame_end = tick && frm_cnt_q == 10'(FRAME_CLKS - 1);
   // divider; the duty split is derived from the same count
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         div_cnt_q <= 16'h0000;
         lcd_clk_q <= 1'b0;
      end else begin
         div_cnt_q <= tick ? 16'h0000 : div_cnt_q + 16'h0001;
         lcd_clk_q <= tick ? 1'b1 : (div_cnt_q + 16'h0001 < hi);
      end
   end
   // frame counter in internal clocks
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         frm_cnt_q <= 10'h000;
         frame_tick_q <= 1'b0;
      end else begin
         frame_tick_q <= frame_end;
         if (tick) begin
            frm_cnt_q <= frame_end ? 10'h000 : frm_cnt_q + 10'h001;
         end
      end
   end
   // shadow to active at the frame boundary, so no frame mixes settings
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         frame_rate_code_q <= lcd_cmd_pkg::CODE_DEFAULT;
         display_on_q <= 1'b0;
         cursor_on_q <= 1'b0;
         blink_on_q <= 1'b0;
         mirror_q <= 1'b0;
         col_rev_q <= 1'b0;
         row_rev_q <= 1'b0;
      end else if (frame_end) begin
         frame_rate_code_q <= sh_code_q;
         display_on_q <= sh_disp_q;
         cursor_on_q <= sh_cur_q;
         blink_on_q <= sh_blink_q;
         mirror_q <= sh_mirror_q;
         col_rev_q <= sh_col_q;
         row_rev_q <= sh_row_q;
      end
   end
   // ****************************************
   // row scan
   // ****************************************
   logic [4:0] steps, char_rows, step_q, lrow;
   logic [9:0] row_cnt_q, row_ticks;
   assign steps = one_line_mux_select ? lcd_cmd_pkg::STEPS_ONE : lcd_cmd_pkg::STEPS_FULL;
   assign char_rows = one_line_mux_select ? lcd_cmd_pkg::CHAR_ROWS_ONE
      : lcd_cmd_pkg::CHAR_ROWS_FULL;
   assign row_ticks = 10'(FRAME_CLKS) / 10'(steps);
   // steps hold in the last row until the frame ends
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         row_cnt_q <= 10'h000;
         step_q <= 5'h00;
      end else if (frame_end) begin
         row_cnt_q <= 10'h000;
         step_q <= 5'h00;
      end else if (tick) begin
         if (row_cnt_q == row_ticks - 10'h001 && step_q != steps - 5'h01) begin
            row_cnt_q <= 10'h000;
            step_q <= step_q + 5'h01;
         end else begin
            row_cnt_q <= row_cnt_q + 10'h001;
         end
      end
   end
   // map the scan step to a physical row
   always_comb begin
      lrow = 5'h00;
      if (step_q < char_rows) begin
         lrow = row_rev_q ? lcd_cmd_pkg::ROW_CHAR_LAST - step_q : step_q;
      end else if (step_q == char_rows) begin
         lrow = row_rev_q ? lcd_cmd_pkg::ROW_ICON_B : lcd_cmd_pkg::ROW_ICON_A;
      end else begin
         lrow = row_rev_q ? lcd_cmd_pkg::ROW_ICON_A : lcd_cmd_pkg::ROW_ICON_B;
      end
   end
   // ****************************************
   // cursor, blink and columns
   // ****************************************
   logic [17:0] blk_cnt_q, blk_half;
   logic blink_phase_q, cur_line;
   assign blk_half = 18'((lcd_cmd_pkg::clk_hz(frame_rate_code_q) * lcd_cmd_pkg::BLINK_PERIOD_MS)
      / 2000);
   assign cur_line = two_line & (addr_counter_q >= lcd_cmd_pkg::LINE1_FIRST);
   assign col_log = col_rev_q ? lcd_cmd_pkg::COL_LAST - col_req : col_req;
   // blink half period counted in internal clocks
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         blk_cnt_q <= 18'h00000;
         blink_phase_q <= 1'b0;
      end else if (tick) begin
         if (blk_cnt_q >= blk_half - 18'h00001) begin
            blk_cnt_q <= 18'h00000;
            blink_phase_q <= ~blink_phase_q;
         end else begin
            blk_cnt_q <= blk_cnt_q + 18'h00001;
         end
      end
   end
   // registered drive outputs
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         drive_row_q <= 5'h00;
         cursor_dots_q <= 5'h00;
         blink_full_q <= 1'b0;
         col_drive_q <= 8'h00;
         col_pair_q <= lcd_cmd_pkg::PAIR_BASE;
      end else begin
         drive_row_q <= lrow;
         cursor_dots_q <= (display_on_q && cursor_on_q && step_q < char_rows
            && step_q == {1'b0, cur_line, lcd_cmd_pkg::CURSOR_DOT_ROW})
            ? lcd_cmd_pkg::CURSOR_DOTS : 5'h00;
         blink_full_q <= display_on_q & blink_on_q & blink_phase_q;
         col_drive_q <= col_log;
         col_pair_q <= mirror_q ? lcd_cmd_pkg::PAIR_TOP - col_log
            : col_log + lcd_cmd_pkg::PAIR_BASE;
      end
   end
endmodule // lcd_display_ctrl
